/* File: inc/pkt_stream_pkg.sv */
/*
 * constants, state codes and helpers for the packet stream master.
 * assumes one shared clock with the slave and a same-clock user side.
 */
// Function
// R1: master alone drives the transfer strobe
// R2: write strobe travels with its payload word
// R3: slave sink captures word on strobe edge
// R4: read strobe answered next edge, captured after
// R5: idle slave source holds qualify flag low
// R6: core strobe follows fill input during reset
// R7: words read during core reset are lost
// R8: fill input held at intended value in reset
// R9: qualify flag marks valid read data only
// R10: qualify and payload hold when strobe low
// R11: fresh word needs qualify and previous strobe
// R12: source fill flag: threshold words or packet end
// R13: sink fill flag: room for threshold words
// R14: read flow follows strobe by one cycle
// R15: after fill drops, read until qualify low
// R16: paused strobe keeps qualify and payload held
// R17: master source limits writes against overflow
// R18: master sink idles until fill flag returns
// R19: ports share width, direction, role, thresholds
// R20: start flag first word, end flag last
// R21: empty count zero except on last word
// R22: abort stays high until after end flag
// R23: payload width 8 to 64, big-endian packed
// R24: fill threshold is a build-time parameter
package pkt_stream_pkg;

    localparam int unsigned DATA_W  = 64;
    localparam int unsigned THRESH  = 4;
    localparam int unsigned CNT_W   = 4;

    // empty-byte count width for a payload width (1 bit kept for 8-bit)
    function automatic int unsigned mty_width(input int unsigned w);
        int unsigned n;
        n = $clog2(w / 8);
        return (n == 0) ? 1 : n;
    endfunction : mty_width

    localparam int unsigned MTY_W = mty_width(DATA_W);

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_READ  = 2'b01,
        RX_DRAIN = 2'b10
    } rx_state_e;

endpackage : pkt_stream_pkg

/* File: rtl/pkt_stream_master.sv */
/*
 * packet stream master: a master source (write) path and a master sink
 * (read) path toward one slave, plus a reset-held fill flag for a core.
 * assumes slave and user logic run on clk_i; rst_i also resets the core.
 */
`timescale 1ns/1ps
module pkt_stream_master #(
    parameter int unsigned DATA_W = pkt_stream_pkg::DATA_W,
    parameter int unsigned MTY_W  = pkt_stream_pkg::MTY_W,
    parameter int unsigned THRESH = pkt_stream_pkg::THRESH,
    parameter int unsigned CNT_W  = pkt_stream_pkg::CNT_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // user write side
    input  wire logic              tx_valid_i,
    output logic                   tx_ready_o,
    input  wire logic [DATA_W-1:0] tx_data_i,
    input  wire logic              tx_sop_i,
    input  wire logic              tx_eop_i,
    input  wire logic [MTY_W-1:0]  tx_mty_i,
    input  wire logic              tx_abort_i,
    // link toward slave sink
    output logic                   tx_strobe_o,
    output logic [DATA_W-1:0]      tx_data_o,
    output logic                   tx_sop_o,
    output logic                   tx_eop_o,
    output logic [MTY_W-1:0]       tx_mty_o,
    output logic                   tx_abort_o,
    input  wire logic              tx_fill_level_ok_i,
    // link toward slave source
    output logic                   rx_strobe_o,
    input  wire logic              rx_qualify_i,
    input  wire logic [DATA_W-1:0] rx_data_i,
    input  wire logic              rx_sop_i,
    input  wire logic              rx_eop_i,
    input  wire logic [MTY_W-1:0]  rx_mty_i,
    input  wire logic              rx_abort_i,
    input  wire logic              rx_fill_level_ok_i,
    // user read side
    input  wire logic              rx_ready_i,
    output logic                   rx_valid_o,
    output logic [DATA_W-1:0]      rx_data_o,
    output logic                   rx_sop_o,
    output logic                   rx_eop_o,
    output logic [MTY_W-1:0]       rx_mty_o,
    output logic                   rx_abort_o,
    // fill flag toward a core whose sink port reads our source
    input  wire logic              src_fill_request_i,
    output logic                   core_fill_level_ok_o
);

    localparam logic [MTY_W-1:0] MTY_NONE = '0;

    logic                    has_credit;
    logic                    tx_take;
    logic                    abort_held;
    logic                    strobe_prev;
    logic                    fresh;
    logic                    dry;
    pkt_stream_pkg::rx_state_e state;
    pkt_stream_pkg::rx_state_e next_state;

    // ---------------- write path ----------------
    // R19 matched threshold
    tx_credit #(
        .THRESH (THRESH),
        .CNT_W  (CNT_W)
    ) u_credit (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .fill_ok_i    (tx_fill_level_ok_i),
        .take_i       (tx_take),
        .has_credit_o (has_credit)
    );

    assign tx_ready_o = has_credit;
    assign tx_take    = tx_valid_i && has_credit;

    // R1 strobe from master
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_strobe_o <= 1'b0;
        end else begin
            tx_strobe_o <= tx_take;
        end
    end

    // R2 word with strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o <= '0;
            tx_sop_o  <= 1'b0;
            tx_eop_o  <= 1'b0;
            tx_mty_o  <= MTY_NONE;
        end else if (tx_take) begin
            // R23 payload passes packed
            tx_data_o <= tx_data_i;
            // R20 packet flags
            tx_sop_o  <= tx_sop_i;
            tx_eop_o  <= tx_eop_i;
            // R21 empty count last only
            tx_mty_o  <= (tx_eop_i && DATA_W > 8) ? tx_mty_i : MTY_NONE;
        end
    end

    // R22 abort stays set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abort_held <= 1'b0;
            tx_abort_o <= 1'b0;
        end else if (tx_take) begin
            abort_held <= (tx_abort_i || abort_held) && !tx_eop_i;
            tx_abort_o <= tx_abort_i || abort_held;
        end
    end

    // ---------------- read path ----------------
    // R11 fresh word test
    assign fresh = strobe_prev && rx_qualify_i;
    assign dry   = strobe_prev && !rx_qualify_i;

    // R14 one cycle read lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_prev <= 1'b0;
        end else begin
            strobe_prev <= rx_strobe_o;
        end
    end

    // R18 idle until fill
    assign rx_strobe_o = !rst_i && (state != pkt_stream_pkg::RX_IDLE)
                         && rx_ready_i;

    // R15 drain after fill drop
    always_comb begin
        next_state = state;
        case (state)
            pkt_stream_pkg::RX_IDLE: begin
                if (rx_fill_level_ok_i) begin
                    next_state = pkt_stream_pkg::RX_READ;
                end
            end
            pkt_stream_pkg::RX_READ: begin
                if (dry) begin
                    next_state = pkt_stream_pkg::RX_IDLE;
                end else if (!rx_fill_level_ok_i) begin
                    next_state = pkt_stream_pkg::RX_DRAIN;
                end
            end
            pkt_stream_pkg::RX_DRAIN: begin
                if (dry) begin
                    next_state = pkt_stream_pkg::RX_IDLE;
                end else if (rx_fill_level_ok_i) begin
                    next_state = pkt_stream_pkg::RX_READ;
                end
            end
            default: begin
                next_state = pkt_stream_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= pkt_stream_pkg::RX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // R4 capture after answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= fresh;
        end
    end

    // R9 qualified data only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_o  <= '0;
            rx_sop_o   <= 1'b0;
            rx_eop_o   <= 1'b0;
            rx_mty_o   <= MTY_NONE;
            rx_abort_o <= 1'b0;
        end else if (fresh) begin
            rx_data_o  <= rx_data_i;
            rx_sop_o   <= rx_sop_i;
            rx_eop_o   <= rx_eop_i;
            rx_mty_o   <= rx_eop_i ? rx_mty_i : MTY_NONE;
            rx_abort_o <= rx_abort_i;
        end
    end

    // R8 fill flag reset held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_fill_level_ok_o <= 1'b0;
        end else begin
            core_fill_level_ok_o <= src_fill_request_i;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_tx_strobe_word: assert property ( // R2
        tx_strobe_o |-> $past(tx_valid_i) && tx_data_o == $past(tx_data_i))
        else $error("write strobe without its word");

    a_tx_strobe_only: assert property ( // R1
        !$past(tx_take) |-> !tx_strobe_o)
        else $error("write strobe without a request");

    a_tx_mty_last: assert property ( // R21
        (tx_strobe_o && !tx_eop_o) |-> tx_mty_o == MTY_NONE)
        else $error("empty count on a non-last word");

    a_tx_abort_held: assert property ( // R22
        ($past(tx_strobe_o && tx_abort_o && !tx_eop_o) && tx_strobe_o)
        |-> tx_abort_o)
        else $error("abort dropped inside packet");

    a_rx_fresh_qual: assert property ( // R11
        rx_valid_o |-> $past(rx_qualify_i) && $past(rx_strobe_o, 2))
        else $error("read word taken without qualify and strobe");

    a_rx_idle_dry: assert property ( // R18
        (state == pkt_stream_pkg::RX_IDLE) |-> !rx_strobe_o)
        else $error("read strobe while idle");

    a_rx_drain_stop: assert property ( // R15
        (state == pkt_stream_pkg::RX_DRAIN && strobe_prev && !rx_qualify_i)
        |=> state == pkt_stream_pkg::RX_IDLE && !rx_strobe_o)
        else $error("drain did not stop on qualify low");

    a_rx_data_match: assert property ( // R9
        rx_valid_o |-> rx_data_o == $past(rx_data_i))
        else $error("read data not the qualified word");

    a_core_fill_reset: assert property (@(posedge clk_i) // R8
        disable iff (1'b0) rst_i |=> !core_fill_level_ok_o)
        else $error("core fill flag high after reset edge");

    c_tx_write: cover property (tx_strobe_o && tx_eop_o);
    c_rx_read: cover property (rx_valid_o ##1 rx_valid_o);
    c_rx_drain: cover property (state == pkt_stream_pkg::RX_DRAIN
                                ##1 state == pkt_stream_pkg::RX_IDLE);
    c_tx_abort: cover property (tx_strobe_o && tx_abort_o && tx_eop_o);

endmodule : pkt_stream_master

/* File: rtl/tx_credit.sv */
/*
 * write credit counter for the master source path.
 * assumes the slave fill flag reflects writes up to the previous edge.
 */
`timescale 1ns/1ps
module tx_credit #(
    parameter int unsigned THRESH = pkt_stream_pkg::THRESH,
    parameter int unsigned CNT_W  = pkt_stream_pkg::CNT_W
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic fill_ok_i,
    input  wire logic take_i,
    output logic      has_credit_o
);

    localparam logic [CNT_W-1:0] FULL = CNT_W'(THRESH);
    localparam logic [CNT_W-1:0] NONE = '0;
    localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);
    localparam logic [CNT_W:0]   CAP  = (CNT_W+1)'(THRESH);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] fresh_credit;
    logic [CNT_W:0]   spent;
    logic             took_prev;

    // R17 word in flight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            took_prev <= 1'b0;
        end else begin
            took_prev <= take_i;
        end
    end

    // in-flight word is not yet counted in the fill flag
    assign fresh_credit = (took_prev && FULL != NONE) ? FULL - ONE : FULL;

    // R17 bounded writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= NONE;
        end else if (fill_ok_i) begin
            count <= (take_i && fresh_credit != NONE) ? fresh_credit - ONE
                                                      : fresh_credit;
        end else if (take_i && count != NONE) begin
            count <= count - ONE;
        end
    end

    assign has_credit_o = fill_ok_i ? (fresh_credit != NONE)
                                    : (count != NONE);

    // R17 words past last fill
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spent <= '0;
        end else if (fill_ok_i) begin
            spent <= (CNT_W+1)'(took_prev) + (CNT_W+1)'(take_i);
        end else begin
            spent <= spent + (CNT_W+1)'(take_i);
        end
    end

    a_credit_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (count == NONE && !fill_ok_i) |-> !take_i) // R17
        else $error("write issued with no credit left");

    a_credit_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        count <= FULL) // R24
        else $error("credit above threshold");

    a_credit_window: assert property (@(posedge clk_i) disable iff (rst_i)
        spent <= CAP) // R17
        else $error("more words sent than the fill flag allows");

endmodule : tx_credit

/* File: tb/slave_model.sv */
/*
 * slave model: a slave sink and a slave source on one shared clock.
 * assumes the master drives both strobes; add_i stocks one source word.
 */
`timescale 1ns/1ps
module slave_model #(
    parameter int DEPTH  = 16,
    parameter int THRESH = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_i,
    input  wire logic        hold_i,
    output logic             room_o,
    output int               used_o,
    input  wire logic        rd_i,
    input  wire logic        add_i,
    input  wire logic        slow_i,
    output logic             val_o,
    output logic [63:0]      dat_o,
    output logic             sop_o,
    output logic             eop_o,
    output logic [2:0]       mty_o,
    output logic             dav_o
);
    int nxt;
    int stock;
    logic give;

    assign give = !slow_i && stock > 0;
    assign dav_o = !rst_i && (stock >= THRESH || stock > 2 - nxt % 3);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            used_o <= 0;
            room_o <= 1'b0;
        end else begin
            used_o <= used_o + int'(wr_i) - int'(!hold_i && used_o > 0);
            room_o <= DEPTH - used_o - int'(wr_i) >= THRESH;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stock <= 0;
            nxt   <= 0;
            val_o <= 1'b0;
            dat_o <= '0;
            sop_o <= 1'b0;
            eop_o <= 1'b0;
            mty_o <= 3'h0;
        end else begin
            stock <= stock + int'(add_i) - int'(rd_i && give);
            if (rd_i) begin
                val_o <= give;
                if (give) begin
                    nxt   <= nxt + 1;
                    dat_o <= {32'(nxt), ~32'(nxt)};
                    sop_o <= nxt % 3 == 0;
                    eop_o <= nxt % 3 == 2;
                    mty_o <= (nxt % 3 == 2) ? 3'(nxt) : 3'h0;
                end else begin
                    dat_o <= ~dat_o;
                end
            end
        end
    end
endmodule : slave_model

/* File: tb/test_pkt_stream_master.sv */
/*
 * self-checking bench for the packet stream master with a slave model.
 * assumes one 100 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module test_pkt_stream_master;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic tx_valid_i, tx_ready_o, tx_sop_i, tx_eop_i, tx_abort_i;
    logic tx_strobe_o, tx_sop_o, tx_eop_o, tx_abort_o, tx_fill_level_ok_i;
    logic rx_strobe_o, rx_qualify_i, rx_sop_i, rx_eop_i, rx_abort_i;
    logic rx_fill_level_ok_i, rx_ready_i, rx_valid_o, rx_sop_o, rx_eop_o;
    logic rx_abort_o, src_fill_request_i, core_fill_level_ok_o;
    logic snk_hold, add, slow, exp_core;
    logic [63:0] tx_data_i, tx_data_o, rx_data_i, rx_data_o;
    logic [2:0]  tx_mty_i, tx_mty_o, rx_mty_i, rx_mty_o;
    logic [69:0] txq[$];
    int          used, rk, cyc, num_errors, n_checks;

    always #5 clk_i = ~clk_i;

    pkt_stream_master u_pkt_stream_master (.clk_i, .rst_i, .tx_valid_i,
        .tx_ready_o, .tx_data_i, .tx_sop_i, .tx_eop_i, .tx_mty_i,
        .tx_abort_i, .tx_strobe_o, .tx_data_o, .tx_sop_o, .tx_eop_o,
        .tx_mty_o, .tx_abort_o, .tx_fill_level_ok_i, .rx_strobe_o,
        .rx_qualify_i, .rx_data_i, .rx_sop_i, .rx_eop_i, .rx_mty_i,
        .rx_abort_i, .rx_fill_level_ok_i, .rx_ready_i, .rx_valid_o,
        .rx_data_o, .rx_sop_o, .rx_eop_o, .rx_mty_o, .rx_abort_o,
        .src_fill_request_i, .core_fill_level_ok_o);

    slave_model #(.THRESH(pkt_stream_pkg::THRESH)) u_slave_model (.clk_i,
        .rst_i, .wr_i(tx_strobe_o),
        .hold_i(snk_hold), .room_o(tx_fill_level_ok_i), .used_o(used),
        .rd_i(rx_strobe_o), .add_i(add), .slow_i(slow),
        .val_o(rx_qualify_i), .dat_o(rx_data_i), .sop_o(rx_sop_i),
        .eop_o(rx_eop_i), .mty_o(rx_mty_i), .dav_o(rx_fill_level_ok_i));

    assign rx_abort_i = 1'((rx_data_i[63:32] / 3) % 2);

    task automatic check(input logic [69:0] seen, input logic [69:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic send(input int n);
        logic [63:0] d;
        logic [2:0]  m;
        logic        a, s, e, ab;
        ab = 1'b0;
        for (int i = 0; i < n; i++) begin
            d = {$urandom, $urandom};
            m = 3'($urandom);
            a = $urandom % 6 == 0;
            s = i % 3 == 0;
            e = i % 3 == 2;
            tx_valid_i <= 1'b1;
            tx_data_i  <= d;
            tx_mty_i   <= m;
            tx_abort_i <= a;
            tx_sop_i   <= s;
            tx_eop_i   <= e;
            do @(posedge clk_i); while (tx_ready_o !== 1'b1);
            txq.push_back({d, s, e, e ? m : 3'h0, a | ab});
            ab = e ? 1'b0 : (a | ab);
        end
        tx_valid_i <= 1'b0;
    endtask : send

    always @(posedge clk_i) begin
        snk_hold           <= $urandom % 3 != 0;
        slow               <= $urandom % 4 == 0;
        rx_ready_i         <= $urandom % 4 != 0;
        src_fill_request_i <= 1'($urandom);
        cyc++;
        if (cyc > 1) check(70'(core_fill_level_ok_o), 70'(exp_core));
        exp_core = rst_i ? 1'b0 : src_fill_request_i;
        if (rst_i) check(70'(rx_strobe_o), 70'(0));
        if (!rst_i && tx_fill_level_ok_i) check(70'(tx_ready_o), 70'(1));
        if (!rst_i && tx_strobe_o) begin
            check({tx_data_o, tx_sop_o, tx_eop_o, tx_mty_o, tx_abort_o},
                  txq.pop_front());
            check(70'(used < 16), 70'(1));
        end
        if (rx_valid_o) begin
            check({rx_data_o, rx_sop_o, rx_eop_o, rx_mty_o, rx_abort_o},
                  {32'(rk), ~32'(rk), rk % 3 == 0, rk % 3 == 2,
                   (rk % 3 == 2) ? 3'(rk) : 3'h0, 1'((rk / 3) % 2)});
            rk++;
        end
    end

    initial begin
        #100000;
        num_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(8));
        {tx_valid_i, tx_sop_i, tx_eop_i, tx_abort_i} = '0;
        {snk_hold, add, slow, rx_ready_i, src_fill_request_i} = '0;
        {tx_data_i, tx_mty_i, exp_core} = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        send(30);
        repeat (60) @(posedge clk_i);
        check(70'(txq.size()), 70'(0));
        $display("write test done");
        repeat (30) begin
            @(posedge clk_i);
            add <= 1'b1;
        end
        @(posedge clk_i);
        add <= 1'b0;
        for (int i = 0; i < 600 && rk < 30; i++) @(posedge clk_i);
        check(70'(rk), 70'(30));
        $display("read test done");
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        $display("reset test done");
        stop_test();
    end
endmodule : test_pkt_stream_master
